// file: eis_edge_detect.sv
// Per-pin edge detector with selectable polarity
`timescale 1ns/10ps
module eis_edge_detect #(
    parameter int N = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Pins and polarity selection
    input wire logic [N-1:0] pinLevel,
    input wire logic [N-1:0] risingSel,
    // Detected edges, one cycle each
    output logic [N-1:0] edgeSeen
);

    logic primed_q;
    logic [N-1:0] prev_q;

    // The first sample after reset only primes the history, so a pin held
    // high through reset does not fake a rising edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            primed_q <= 1'b0;
            prev_q <= '0;
        end else begin
            primed_q <= 1'b1;
            prev_q <= pinLevel;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            wire rise = pinLevel[i] & ~prev_q[i];
            wire fall = ~pinLevel[i] & prev_q[i];
            assign edgeSeen[i] = primed_q & (risingSel[i] ? rise : fall);
        end
    endgenerate

endmodule

// file: eis_ext_irq_edge_select.sv
// Top: external request edge select, sticky status, mask and APB registers
`timescale 1ns/10ps
module eis_ext_irq_edge_select (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Request pins, synchronous to sys_clk
    input wire logic nonmaskablePin,
    input wire logic [3:0] extRequestPin,

    // Requests toward the processor
    output logic nonmaskableRequest,
    output logic [3:0] extRequest,
    output logic irqOut
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [4:0] polarity_q;
    logic [4:0] polarity_d;
    logic [4:0] mask_q;
    logic [4:0] mask_d;
    logic cpuMask_q;
    logic cpuMask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic nmiReq_q;
    logic [3:0] extReq_q;
    logic irq_q;

    eis_pkg::eis_src_t pinLevel;
    eis_pkg::eis_src_t edgeSeen;
    eis_pkg::eis_src_t statusFlags;
    eis_pkg::eis_src_t clrMask;
    eis_pkg::eis_src_t effMask;
    eis_pkg::eis_src_t pending;

    // ****************************************
    // Address decode
    // ****************************************
    wire selPolarity = (paddr == eis_pkg::OFS_POLARITY);
    wire selStatus = (paddr == eis_pkg::OFS_STATUS);
    wire selMask = (paddr == eis_pkg::OFS_MASK);
    wire selCpuMask = (paddr == eis_pkg::OFS_CPU_MASK);
    wire addrHit = selPolarity | selStatus | selMask | selCpuMask;

    wire setupPhase = psel & ~penable;
    wire accessPhase = psel & penable;
    wire readSetup = setupPhase & ~pwrite;
    wire writeAccess = accessPhase & pwrite & addrHit;
    wire readAccess = accessPhase & ~pwrite;

    wire wrPolarity = writeAccess & selPolarity;
    wire wrMask = writeAccess & selMask;
    wire wrCpuMask = writeAccess & selCpuMask;
    wire rdStatusDone = readAccess & selStatus;

    // Never waits; unmapped addresses answer with an error and read zero
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~addrHit;

    // ****************************************
    // Read data views
    // ****************************************
    // Reserved bits are not stored at all, so a write cannot touch them
    wire [7:0] polarityView = {polarity_q[4], eis_pkg::POL_RSVD_VALUE, polarity_q[3:0]};
    wire [31:0] readMux =
        selPolarity ? {24'h000000, polarityView} :
        selStatus ? {27'h0000000, statusFlags} :
        selMask ? {27'h0000000, mask_q} :
        selCpuMask ? {31'h00000000, cpuMask_q} :
        32'h00000000;

    // Data is captured in the setup cycle so it is stable through access
    assign prdata_d = readSetup ? readMux : prdata_q;
    assign prdata = prdata_q;

    // ****************************************
    // Control registers
    // ****************************************
    // Polarity: bit 4 of the store is the non-maskable pin, 3..0 the request pins
    assign polarity_d = wrPolarity ?
        {pwdata[eis_pkg::POL_NMI_BIT], pwdata[3:0]} : polarity_q;
    assign mask_d = wrMask ? pwdata[4:0] : mask_q;
    assign cpuMask_d = wrCpuMask ? pwdata[eis_pkg::CPU_MASK_BIT] : cpuMask_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            polarity_q <= eis_pkg::POLARITY_RESET;
            mask_q <= eis_pkg::MASK_RESET;
            cpuMask_q <= eis_pkg::CPU_MASK_RESET;
            prdata_q <= 32'h00000000;
        end else begin
            polarity_q <= polarity_d;
            mask_q <= mask_d;
            cpuMask_q <= cpuMask_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // Edge detection
    // ****************************************
    assign pinLevel.nmi = nonmaskablePin;
    assign pinLevel.req = extRequestPin;

    // Polarity bit 0 selects falling, 1 selects rising, for every source
    eis_edge_detect #(
        .N(eis_pkg::NUM_SRC)
    ) u_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinLevel(pinLevel),
        .risingSel(polarity_q),
        .edgeSeen(edgeSeen)
    );

    // ****************************************
    // Sticky status, cleared by read
    // ****************************************
    // Only the bits actually returned are cleared, so an edge that lands
    // between setup and access survives the read
    assign clrMask = rdStatusDone ? prdata_q[4:0] : 5'h00;

    eis_sticky_flags #(
        .N(eis_pkg::NUM_SRC)
    ) u_flags (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .setPulse(edgeSeen),
        .clrMask(clrMask),
        .flags(statusFlags)
    );

    // ****************************************
    // Masking and request outputs
    // ****************************************
    assign effMask.nmi = mask_q[eis_pkg::SRC_NMI_BIT];
    assign effMask.req = mask_q[3:0] & {4{~cpuMask_q}};
    assign pending = statusFlags & effMask;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            nmiReq_q <= 1'b0;
            extReq_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            nmiReq_q <= pending.nmi;
            extReq_q <= pending.req;
            irq_q <= |pending;
        end
    end

    assign nonmaskableRequest = nmiReq_q;
    assign extRequest = extReq_q;
    assign irqOut = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    chk_nmi_fall_edge: assert property (
        $past(rst_b) && !polarity_q[4] && $fell(nonmaskablePin) |=> statusFlags.nmi)
        else $error("falling edge on non-maskable pin not flagged");

    chk_nmi_rise_edge: assert property (
        $past(rst_b) && polarity_q[4] && $rose(nonmaskablePin) |=> statusFlags.nmi)
        else $error("rising edge on non-maskable pin not flagged");

    chk_req3_edge_sel: assert property (
        $past(rst_b) && (polarity_q[3] ? $rose(extRequestPin[3]) : $fell(extRequestPin[3]))
        |=> statusFlags.req[3])
        else $error("request pin 3 edge not flagged");

    chk_req2_edge_sel: assert property (
        $past(rst_b) && (polarity_q[2] ? $rose(extRequestPin[2]) : $fell(extRequestPin[2]))
        |=> statusFlags.req[2])
        else $error("request pin 2 edge not flagged");

    chk_req1_edge_sel: assert property (
        $past(rst_b) && (polarity_q[1] ? $rose(extRequestPin[1]) : $fell(extRequestPin[1]))
        |=> statusFlags.req[1])
        else $error("request pin 1 edge not flagged");

    chk_req0_edge_sel: assert property (
        $past(rst_b) && (polarity_q[0] ? $rose(extRequestPin[0]) : $fell(extRequestPin[0]))
        |=> statusFlags.req[0])
        else $error("request pin 0 edge not flagged");

    chk_no_false_edge: assert property (
        $stable(nonmaskablePin) && $stable(extRequestPin) |-> edgeSeen == 5'h00)
        else $error("edge flagged on a steady pin");

    chk_wrong_dir_quiet: assert property (
        $past(rst_b) && !polarity_q[4] && $rose(nonmaskablePin) |-> !edgeSeen.nmi)
        else $error("edge of the unselected direction flagged");

    // Only the selected edge may flag; the opposite edge of every source is ignored
    chk_nmi_fall_quiet: assert property (
        polarity_q[4] && $fell(nonmaskablePin) |-> !edgeSeen.nmi)
        else $error("falling edge flagged on non-maskable pin set for rising");

    chk_req3_wrong_dir: assert property (
        (polarity_q[3] ? $fell(extRequestPin[3]) : $rose(extRequestPin[3]))
        |-> !edgeSeen.req[3])
        else $error("request pin 3 edge of the unselected direction flagged");

    chk_req2_wrong_dir: assert property (
        (polarity_q[2] ? $fell(extRequestPin[2]) : $rose(extRequestPin[2]))
        |-> !edgeSeen.req[2])
        else $error("request pin 2 edge of the unselected direction flagged");

    chk_req1_wrong_dir: assert property (
        (polarity_q[1] ? $fell(extRequestPin[1]) : $rose(extRequestPin[1]))
        |-> !edgeSeen.req[1])
        else $error("request pin 1 edge of the unselected direction flagged");

    chk_req0_wrong_dir: assert property (
        (polarity_q[0] ? $fell(extRequestPin[0]) : $rose(extRequestPin[0]))
        |-> !edgeSeen.req[0])
        else $error("request pin 0 edge of the unselected direction flagged");

    chk_rsvd_read_one: assert property (
        readSetup && selPolarity |=> prdata[6:4] == 3'h7)
        else $error("reserved control bits did not read as one");

    chk_pol_write_take: assert property (
        wrPolarity |=> polarity_q == {$past(pwdata[7]), $past(pwdata[3:0])})
        else $error("polarity write not taken");

    chk_pol_hold: assert property (
        !wrPolarity |=> $stable(polarity_q))
        else $error("polarity changed without a write");

    chk_mask_take: assert property (
        wrMask |=> mask_q == $past(pwdata[4:0]))
        else $error("mask write not taken");

    chk_cpu_mask_hold: assert property (
        cpuMask_q && !(statusFlags.nmi && mask_q[4]) |=> !irqOut && extRequest == 4'h0)
        else $error("request pin passed while processor mask set");

    chk_cpu_mask_take: assert property (
        wrCpuMask |=> cpuMask_q == $past(pwdata[0]))
        else $error("processor mask write not taken");

    chk_req_gate_open: assert property (
        !cpuMask_q |=> extRequest == $past(statusFlags.req & mask_q[3:0]))
        else $error("unmasked request pin held off");

    chk_irq_level: assert property (
        (statusFlags & effMask) != 5'h00 |=> irqOut)
        else $error("unmasked status bit set but interrupt output low");

    chk_nmi_unmasked: assert property (
        statusFlags.nmi && mask_q[4] |=> irqOut && nonmaskableRequest)
        else $error("non-maskable request held off");

    chk_status_rd_clr: assert property (
        rdStatusDone && (prdata_q[4:0] & edgeSeen) == 5'h00 |=> (statusFlags & $past(prdata_q[4:0])) == 5'h00)
        else $error("status read did not clear returned bits");

    // Flags only fall on a status read; anything else dropping them loses an event
    chk_status_sticky: assert property (
        !rdStatusDone |=> (statusFlags & $past(statusFlags)) == $past(statusFlags))
        else $error("status flag dropped without a read");

    cov_nmi_to_irq: cover property (
        $rose(nonmaskablePin) && polarity_q[4] && mask_q[4] ##2 irqOut);

    cov_masked_req: cover property (
        statusFlags.req[0] && mask_q[0] && cpuMask_q);

    cov_status_clear: cover property (
        rdStatusDone && prdata_q[4:0] != 5'h00);

    cov_unmapped_access: cover property (pslverr);

    cov_set_meets_clear: cover property (
        rdStatusDone && (prdata_q[4:0] & edgeSeen) != 5'h00);

endmodule

// file: eis_ext_irq_edge_select_bench.sv
// Self-checking bench of the external request edge select block
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module eis_ext_irq_edge_select_bench;
    // ********************************
    // Signals
    // ********************************
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, nmiReq, irqOut, slowMode, rdErr, expCpu;
    logic [7:0] paddr, expPol;
    logic [31:0] pwdata, prdata, rnd, rd, wd;
    logic [3:0] extReq;
    eis_pkg::eis_src_t target, pins, prevPins, expStat, expMask;
    int errors, checks_done;

    eis_ext_irq_edge_select eis_ext_irq_edge_select_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nonmaskablePin(pins.nmi), .extRequestPin(pins.req), .nonmaskableRequest(nmiReq),
        .extRequest(extReq), .irqOut(irqOut));
    eis_pin_model eis_pin_model_inst (.sys_clk(sys_clk), .slowMode(slowMode), .target(target), .pins(pins));

    // ********************************
    // Reference model
    // ********************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // A change between two samples that ends on the selected level
    function automatic eis_pkg::eis_src_t edges_of(input eis_pkg::eis_src_t p, c, input logic [7:0] pol);
        logic [4:0] rise;
        rise = {pol[7], pol[3:0]};
        return (p ^ c) & ~(c ^ rise);
    endfunction

    always @(posedge sys_clk) begin
        if (rst_b)
            expStat = expStat | edges_of(prevPins, pins, expPol);
        prevPins = pins;
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK(rd, e)
        `CHK(rdErr, 1'b0)
    endtask

    task automatic out_chk();
        logic [3:0] er;
        er = expStat.req & expMask.req & {4{~expCpu}};
        `CHK(nmiReq, expStat.nmi & expMask.nmi)
        `CHK(extReq, er)
        `CHK(irqOut, (expStat.nmi & expMask.nmi) | (|er))
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ********************************
    // Clock, watchdog and sequence
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // The sequence needs under 2000 cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end

    initial begin
        {rst_b, psel, penable, pwrite, slowMode, expCpu} = 6'h01;
        paddr = 8'h00;
        pwdata = 32'h0;
        target = '0;
        expStat = '0;
        expMask = '0;
        expPol = 8'h70;
        errors = 0;
        checks_done = 0;
        rnd = 32'hF8753D0A;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(eis_pkg::OFS_POLARITY, 32'h70);
        rd_chk(eis_pkg::OFS_STATUS, 32'h0);
        rd_chk(eis_pkg::OFS_MASK, 32'h0);
        rd_chk(eis_pkg::OFS_CPU_MASK, 32'h1);
        apb(8'h10, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(rdErr, 1'b1)
        apb(8'h10, 1'b1, 32'hFFFFFFFF);
        `CHK(rdErr, 1'b1)
        rd_chk(eis_pkg::OFS_POLARITY, 32'h70);
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr_next(rnd);
            // First passes pin every polarity to one and then to zero
            wd = (i == 0) ? 32'hFF : (i == 1) ? 32'h0 : rnd;
            apb(eis_pkg::OFS_POLARITY, 1'b1, wd);
            expPol = (wd[7:0] & 8'h8F) | 8'h70;
            rd_chk(eis_pkg::OFS_POLARITY, {24'h0, expPol});
            expMask = rnd[12:8];
            expCpu = rnd[13];
            apb(eis_pkg::OFS_MASK, 1'b1, {27'h0, expMask});
            apb(eis_pkg::OFS_CPU_MASK, 1'b1, {31'h0, expCpu});
            slowMode <= rnd[14];
            for (int k = 0; k < 8; k++) begin
                rnd = lfsr_next(rnd);
                target <= rnd[20:16];
                @(posedge sys_clk);
            end
            repeat (4) @(posedge sys_clk);
            out_chk();
            apb(eis_pkg::OFS_STATUS, 1'b0, 32'h0);
            `CHK(rd[4], expStat.nmi)
            `CHK(rd[3], expStat.req[3])
            `CHK(rd[2], expStat.req[2])
            `CHK(rd[1], expStat.req[1])
            `CHK(rd[0], expStat.req[0])
            expStat = '0;
            repeat (3) @(posedge sys_clk);
            out_chk();
        end
        // Corner case: a fresh rising edge lands on the access edge of a status
        // read that returns the same bits, so the set must win over the clear
        slowMode <= 1'b0;
        apb(eis_pkg::OFS_POLARITY, 1'b1, 32'hFF);
        expPol = 8'hFF;
        target <= '0;
        repeat (4) @(posedge sys_clk);
        apb(eis_pkg::OFS_STATUS, 1'b0, 32'h0);
        target <= '1;
        @(posedge sys_clk);
        target <= '0;
        @(posedge sys_clk);
        target <= '1;
        apb(eis_pkg::OFS_STATUS, 1'b0, 32'h0);
        `CHK(rd, 32'h1F)
        rd_chk(eis_pkg::OFS_STATUS, 32'h1F);
        rd_chk(eis_pkg::OFS_STATUS, 32'h0);
        expStat = '0;
        end_of_test();
    end
endmodule

// file: eis_pin_model.sv
// Behavioural model of the external devices that drive the request pins
`timescale 1ns/10ps
module eis_pin_model (
    // Clock
    input wire logic sys_clk,
    // Control from the bench
    input wire logic slowMode,
    input wire eis_pkg::eis_src_t target,
    // Pin levels
    output eis_pkg::eis_src_t pins
);
    eis_pkg::eis_src_t stage;

    // Slow devices settle one cycle late; the bench model watches the pins, not the target
    always @(posedge sys_clk) begin
        stage <= target;
        pins <= slowMode ? stage : target;
    end
endmodule

// file: eis_pkg.sv
// Package: constants and types of the external request edge select block
package eis_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int NUM_REQ = 4;
    localparam int NUM_SRC = 5;
    localparam int ADDR_W = 8;

    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] OFS_POLARITY = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_CPU_MASK = 8'h0C;

    // ********************************
    // Field positions
    // ********************************
    localparam int POL_NMI_BIT = 7;
    localparam int POL_RSVD_LSB = 4;
    localparam int POL_RSVD_MSB = 6;
    localparam int SRC_NMI_BIT = 4;
    localparam int CPU_MASK_BIT = 0;

    // ********************************
    // Reset and fixed values
    // ********************************
    localparam logic [2:0] POL_RSVD_VALUE = 3'h7;
    localparam logic [4:0] POLARITY_RESET = 5'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic CPU_MASK_RESET = 1'b1;

    // ********************************
    // Types
    // ********************************
    // One bit per request source: the non-maskable pin on top, then pins 3..0
    typedef struct packed {
        logic nmi;
        logic [3:0] req;
    } eis_src_t;

endpackage

// file: eis_sticky_flags.sv
// Sticky event flags with masked clear; a set wins over a clear
`timescale 1ns/10ps
module eis_sticky_flags #(
    parameter int N = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Events and clear
    input wire logic [N-1:0] setPulse,
    input wire logic [N-1:0] clrMask,
    // Flag state
    output logic [N-1:0] flags
);

    logic [N-1:0] flags_q;
    logic [N-1:0] flags_d;

    assign flags_d = (flags_q & ~clrMask) | setPulse;
    assign flags = flags_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            flags_q <= eis_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    chk_set_wins_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (setPulse & clrMask) != '0 |=> (flags_q & $past(setPulse & clrMask)) == $past(setPulse & clrMask))
        else $error("flag set lost against a clear");

endmodule
